// File: bench/dsp_far_uart.sv
// Partner: remote serial transceiver on the far end of the line
`timescale 1ns/1ps
`default_nettype none
module dsp_far_uart
  import dsp_pkg::*;
#(
  parameter int BIT = BAUD_RESET
)
(
  input wire logic ref_clk,
  input wire logic txLine,
  output logic rxLine,
  output logic ctsN
);
  logic [7:0] rxQ [$];
  logic [7:0] rxByte;
  initial begin
    rxLine = 1'h1;
    ctsN = 1'h0;
  end
  task automatic send(input logic [7:0] b, input logic par, badPar, badStop);
    logic [11:0] f;
    f = par ? {1'h1, ~badStop, ^b ^ badPar, b, 1'h0} : {2'h3, ~badStop, b, 1'h0};
    for (int i = 0; i < 12; i++) begin
      rxLine <= f[i];
      repeat (BIT) @(posedge ref_clk);
    end
  endtask : send
  always begin
    @(negedge txLine);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge ref_clk);
      rxByte[i] = txLine;
    end
    repeat (BIT) @(posedge ref_clk);
    rxQ.push_back(rxByte);
  end
endmodule : dsp_far_uart
`default_nettype wire

// File: bench/dsp_serial_port_properties.sv
// Checker: port properties of the serial port
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_port_chk
  import dsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire dsp_mem_t mem,
  input wire logic memAck,
  input wire logic txLine
);
  logic [15:0] lowCnt_r;
  logic [15:0] highCnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Run lengths saturate; idle after reset counts as long high
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lowCnt_r <= 16'h0000;
      highCnt_r <= 16'hFFFF;
    end else begin
      lowCnt_r <= txLine ? 16'h0000 : lowCnt_r + {15'h0000, ~&lowCnt_r};
      highCnt_r <= txLine ? highCnt_r + {15'h0000, ~&highCnt_r} : 16'h0000;
    end
  end
  chk_low_run: assert property ($rose(txLine) |-> lowCnt_r >= BAUD_MIN)
    else $error("low level shorter than a bit");
  chk_high_run: assert property ($fell(txLine) |-> highCnt_r >= BAUD_MIN)
    else $error("high level shorter than a bit");
  chk_dma_hold: assert property (
    mem.req && !memAck |=> mem.req && $stable(mem))
    else $error("memory request changed before ack");
  chk_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("no write response");
  chk_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (
    arvalid && arready |-> ##[0:2] rvalid)
    else $error("no read response");
  chk_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read response dropped");
  chk_ar_pulse: assert property (arready |=> !arready)
    else $error("read ready not a pulse");
  cov_tx_start: cover property ($fell(txLine));
  cov_dma_write: cover property (mem.req && mem.wr && memAck);
  cov_read_error: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : dsp_serial_port_chk
bind dsp_serial_port dsp_serial_port_chk chk_u (.ref_clk, .nrst, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .mem, .memAck, .txLine);
`default_nettype wire

// File: bench/tb_dsp_serial_port.sv
// Testbench: register, DMA and serial scenarios of the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_serial_port;
  import dsp_pkg::*;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, memAck = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, txLine, rxLine, ctsN, rtsN;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] memRdata = 8'h00;
  logic [7:0] memArr [0:255];
  dsp_mem_t mem;
  int miscompares = 0;
  int num_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  dsp_serial_port dut_u (.ref_clk, .nrst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .mem, .memAck,
    .memRdata, .rxLine, .txLine, .ctsN, .rtsN);
  dsp_far_uart far_u (.ref_clk, .txLine, .rxLine, .ctsN);
  // Memory acks one cycle late; idle read data keeps toggling
  always @(posedge ref_clk) begin
    memAck <= mem.req && !memAck;
    memRdata <= mem.req && !mem.wr ? mem.addr[7:0] ^ 8'hA5 : ~memRdata;
    if (mem.req && mem.wr && memAck) memArr[mem.addr[7:0]] <= mem.wdata;
  end
  task automatic check(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 1000);
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 1000);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd
  task automatic reg_is(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, e, "register");
  endtask : reg_is
  // Polls events under a bound, then clears them all
  task automatic wait_ev(input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(ADDR_EVENTS, d, r);
      n++;
    end while ((d & m) !== m && n < 4000);
    check(d & m, m, "events");
    wr(ADDR_EVENTS, 32'hFFFFFFFF);
  endtask : wait_ev
  task automatic rx_start(input logic [31:0] p, l);
    wr(ADDR_RXPTR, p);
    wr(ADDR_RXLIM, l);
    wr(ADDR_TASKS, 32'h1 << T_BEGIN_RX);
    wait_ev(32'h1 << E_RX_BEGUN);
  endtask : rx_start
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    rd(12'h100, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped");
    reg_is(ADDR_BAUD, 32'hC8);
    $display("t_bus done");
  endtask : t_bus
  task automatic t_transmit;
    wr(ADDR_TXPTR, 32'h40);
    wr(ADDR_TXLIM, 32'h2);
    wr(ADDR_TASKS, 32'h1 << T_BEGIN_TX);
    wait_ev(32'h1 << E_TX_BEGUN);
    wr(ADDR_TXPTR, 32'h80);
    wait_ev(32'h1 << E_TX_DONE | 32'h1 << E_BYTE_TX);
    check({24'h0, far_u.rxQ[0]}, 32'h40 ^ 32'hA5, "tx 0");
    check({24'h0, far_u.rxQ[1]}, 32'h41 ^ 32'hA5, "tx 1");
    reg_is(ADDR_TXAMT, 32'h2);
    $display("t_transmit done");
  endtask : t_transmit
  task automatic t_receive;
    rx_start(32'h10, 32'h2);
    far_u.send(8'h35, 1'h0, 1'h0, 1'h0);
    far_u.send(8'hCA, 1'h0, 1'h0, 1'h0);
    wait_ev(32'h1 << E_RX_DONE | 32'h1 << E_BYTE_RX);
    check({24'h0, memArr[8'h10]}, 32'h35, "rx 0");
    check({24'h0, memArr[8'h11]}, 32'hCA, "rx 1");
    reg_is(ADDR_RXAMT, 32'h2);
    $display("t_receive done");
  endtask : t_receive
  task automatic t_halt_rx;
    rx_start(32'h20, 32'h8);
    far_u.send(8'h5A, 1'h0, 1'h0, 1'h0);
    wr(ADDR_TASKS, 32'h1 << T_HALT_RX);
    wait_ev(32'h1 << E_RX_DONE | 32'h1 << E_RX_TO);
    check({24'h0, memArr[8'h20]}, 32'h5A, "halt rx");
    reg_is(ADDR_RXAMT, 32'h1);
    $display("t_halt_rx done");
  endtask : t_halt_rx
  task automatic t_errors;
    wr(ADDR_CONFIG, 32'h1 << C_PARITY);
    rx_start(32'h30, 32'h8);
    far_u.send(8'h3C, 1'h1, 1'h1, 1'h0);
    far_u.send(8'h71, 1'h1, 1'h0, 1'h1);
    far_u.send(8'h99, 1'h1, 1'h0, 1'h0);
    wr(ADDR_TASKS, 32'h1 << T_HALT_RX);
    wait_ev(32'h1 << E_ERROR | 32'h1 << E_RX_TO);
    check({24'h0, memArr[8'h30]}, 32'h3C, "parity");
    check({24'h0, memArr[8'h31]}, 32'h99, "framing");
    reg_is(ADDR_RXAMT, 32'h2);
    $display("t_errors done");
  endtask : t_errors
  task automatic t_halt_tx;
    logic [31:0] d;
    logic [1:0] r;
    wr(ADDR_TXLIM, 32'h4);
    wr(ADDR_TASKS, 32'h1 << T_BEGIN_TX);
    wait_ev(32'h1 << E_TX_BEGUN);
    wr(ADDR_TASKS, 32'h1 << T_HALT_TX);
    wait_ev(32'h1 << E_TX_HALTED | 32'h1 << E_TX_DONE);
    rd(ADDR_TXAMT, d, r);
    check({31'h0, d < 32'h4}, 32'h1, "tx cut short");
    $display("t_halt_tx done");
  endtask : t_halt_tx
  task automatic t_drain;
    wr(ADDR_RXPTR, 32'h60);
    wr(ADDR_RXLIM, 32'h8);
    wr(ADDR_TASKS, 32'h1 << T_DRAIN);
    wait_ev(32'h1 << E_RX_DONE);
    reg_is(ADDR_RXAMT, 32'h0);
    $display("t_drain done");
  endtask : t_drain
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'h1;
    t_bus;
    t_transmit;
    t_receive;
    t_halt_rx;
    t_errors;
    t_halt_tx;
    t_drain;
    wrap_up;
  end
  // Over twice the expected run of some thirty-eight thousand cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    wrap_up;
  end
endmodule : tb_dsp_serial_port
`default_nettype wire

// File: rtl/dsp_pkg.sv
// Package: constants, register map and carrier types for the serial port
package dsp_pkg;
  localparam int CLK_HZ = 200000000;
  localparam logic [7:0] FIFO_DEPTH = 8'h08;
  localparam logic [7:0] RTS_ROOM = 8'h04;
  localparam logic [3:0] RTS_GRACE = 4'h4;
  localparam logic [11:0] ADDR_TASKS = 12'h000;
  localparam logic [11:0] ADDR_EVENTS = 12'h004;
  localparam logic [11:0] ADDR_CONFIG = 12'h008;
  localparam logic [11:0] ADDR_BAUD = 12'h00C;
  localparam logic [11:0] ADDR_RXPTR = 12'h010;
  localparam logic [11:0] ADDR_RXLIM = 12'h014;
  localparam logic [11:0] ADDR_RXAMT = 12'h018;
  localparam logic [11:0] ADDR_TXPTR = 12'h01C;
  localparam logic [11:0] ADDR_TXLIM = 12'h020;
  localparam logic [11:0] ADDR_TXAMT = 12'h024;
  localparam logic [11:0] ADDR_STATUS = 12'h028;
  localparam int T_BEGIN_RX = 0;
  localparam int T_HALT_RX = 1;
  localparam int T_BEGIN_TX = 2;
  localparam int T_HALT_TX = 3;
  localparam int T_DRAIN = 4;
  localparam int E_BYTE_RX = 0;
  localparam int E_RX_DONE = 1;
  localparam int E_BYTE_TX = 2;
  localparam int E_TX_DONE = 3;
  localparam int E_ERROR = 4;
  localparam int E_RX_TO = 5;
  localparam int E_RX_BEGUN = 6;
  localparam int E_TX_BEGUN = 7;
  localparam int E_TX_HALTED = 8;
  localparam int NEV = 9;
  localparam int C_FLOW = 0;
  localparam int C_PARITY = 1;
  localparam int C_STOP2 = 2;
  localparam logic [15:0] BAUD_RESET = 16'h00C8;
  localparam logic [15:0] BAUD_MIN = 16'h00C8;
  localparam logic [12:0] LIM_RESET = 13'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {TX_IDLE, TX_FETCH, TX_WAIT, TX_SHIFT, TX_END} dsp_txst_t;
  typedef enum {RX_OFF, RX_ON, RX_STOPPING, RX_DRAINING} dsp_rxst_t;
  typedef struct packed {
    logic [31:0] ptr;
    logic [12:0] lim;
  } dsp_buf_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [7:0] wdata;
  } dsp_mem_t;
endpackage : dsp_pkg

// File: rtl/dsp_serial_port.sv
// Module: serial port with byte DMA and AXI4-Lite register slave
// Function
// - Characters go out and come in least significant bit first.
// - One or two stop bits, optional even parity generated and checked.
// - Full duplex, baud divisor allows rates up to one megabit.
// - Pointer and limit are copied at start; new writes affect next.
// - Buffer done events follow the last completed memory access.
// - Begin transmit fetches bytes from pointer up to limit.
// - Byte sent event after each character fully shifted out.
// - Transmit ends itself after limit bytes, raising buffer done.
// - Halt transmit stops transmitter, then raises halted event.
// - Early halt still raises transmit buffer done.
// - Flow control: finish character, pause while clear-to-send inactive.
// - Begin receive stores bytes from pointer, done at limit.
// - Byte received event per character, possibly before memory write.
// - Readable count of bytes written since the last begin receive or drain.
// - Halt receive raises timeout after stop, pending done first.
// - Outstanding receive done raised before timeout even if not full.
// - Four more characters accepted after request-to-send drops.
// - Drain, from receiver off only, moves FIFO to memory up to limit, then always raises receive done.
// - Flow control drops request-to-send on halt or four slots left.
// - No flow control: request-to-send unused, overflow characters lost.
// - Bad stop bit raises error, byte dropped, reception continues.
// - Parity error raises error, byte still stored.
// - Flow control off acts as clear-to-send always asserted.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_port
  import dsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output dsp_mem_t mem,
  input wire logic memAck,
  input wire logic [7:0] memRdata,
  input wire logic rxLine,
  output logic txLine,
  input wire logic ctsN,
  output logic rtsN
);
  typedef struct packed {
    logic awHave, wHave, arDone;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [NEV-1:0] ev;
    logic [2:0] cfg;
    logic [15:0] baud;
    dsp_buf_t rxSet, txSet, rxCur, txCur;
    logic [12:0] rxAmt, txAmt;
    dsp_mem_t mem;
    logic memIsTx;
    dsp_txst_t txSt;
    logic txHalt;
    logic [7:0] txByte;
    logic [3:0] txBit;
    logic [15:0] txCnt;
    logic [10:0] txSr;
    logic txLine;
    logic cts1, cts2;
    dsp_rxst_t rxSt;
    logic rxDonePend;
    logic rx1, rx2;
    logic rxBusy;
    logic rxArmed;
    logic [15:0] rxCnt;
    logic [3:0] rxBit;
    logic [9:0] rxSr;
    logic [7:0][7:0] fifo;
    logic [2:0] wp, rp;
    logic [3:0] cnt;
    logic [3:0] grace;
    logic [18:0] graceCnt;
    logic rtsN;
  } st_t;
  st_t r, n;
  logic [4:0] task_s;
  logic wrFire, rdFire, parErr, stopOk, pushOk, charEnd;
  logic [3:0] nbits;
  logic [31:0] rv;
  always_comb begin
    n = r;
    task_s = '0;
    rv = 32'h00000000;
    // Bus slave: address and data accepted in either order
    if (awvalid && !r.awHave) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && !r.wHave) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    wrFire = r.awHave && r.wHave && !r.bValid;
    if (r.bValid && bready) begin
      n.bValid = 1'b0;
    end
    if (wrFire) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = RESP_OKAY;
      unique case (r.awAddr)
        ADDR_TASKS: begin
          if (r.wStrb[0]) begin
            task_s = r.wData[4:0];
          end
        end
        ADDR_EVENTS: begin
          if (r.wStrb[1:0] != 2'h0) begin
            n.ev = r.ev & ~r.wData[NEV-1:0];
          end
        end
        ADDR_CONFIG: begin
          if (r.wStrb[0]) begin
            n.cfg = r.wData[2:0];
          end
        end
        ADDR_BAUD: begin
          n.baud = (r.wData[15:0] < BAUD_MIN) ? BAUD_MIN : r.wData[15:0];
        end
        ADDR_RXPTR: n.rxSet.ptr = r.wData;
        ADDR_RXLIM: n.rxSet.lim = r.wData[12:0];
        ADDR_TXPTR: n.txSet.ptr = r.wData;
        ADDR_TXLIM: n.txSet.lim = r.wData[12:0];
        ADDR_RXAMT, ADDR_TXAMT, ADDR_STATUS: ;
        default: n.bResp = RESP_SLVERR;
      endcase
    end
    // Address taken only while arready stands high
    rdFire = arvalid && r.arDone;
    n.arDone = arvalid && !r.arDone && !r.rValid;
    if (r.rValid && rready) begin
      n.rValid = 1'b0;
    end
    if (rdFire) begin
      n.rValid = 1'b1;
      n.rResp = RESP_OKAY;
      unique case (araddr)
        ADDR_EVENTS: rv = {23'h0, r.ev};
        ADDR_CONFIG: rv = {29'h0, r.cfg};
        ADDR_BAUD: rv = {16'h0, r.baud};
        ADDR_RXPTR: rv = r.rxSet.ptr;
        ADDR_RXLIM: rv = {19'h0, r.rxSet.lim};
        ADDR_RXAMT: rv = {19'h0, r.rxAmt};
        ADDR_TXPTR: rv = r.txSet.ptr;
        ADDR_TXLIM: rv = {19'h0, r.txSet.lim};
        ADDR_TXAMT: rv = {19'h0, r.txAmt};
        ADDR_STATUS: rv = {24'h0, r.rtsN, r.cts2, r.cnt, r.rxSt != RX_OFF,
          r.txSt != TX_IDLE};
        ADDR_TASKS: rv = 32'h00000000;
        default: n.rResp = RESP_SLVERR;
      endcase
      n.rData = rv;
    end
    nbits = r.cfg[C_PARITY] ? 4'hA : 4'h9;
    if (r.cfg[C_STOP2]) begin
      nbits = nbits + 4'h1;
    end
    n.cts2 = r.cts1;
    n.cts1 = ctsN;
    n.rx2 = r.rx1;
    n.rx1 = rxLine;
    // Memory port, one access at a time
    if (r.mem.req && memAck) begin
      n.mem.req = 1'b0;
    end
    // Transmitter
    if (task_s[T_HALT_TX] && r.txSt != TX_IDLE) begin
      n.txHalt = 1'b1;
    end
    unique case (r.txSt)
      TX_IDLE: begin
        if (task_s[T_BEGIN_TX]) begin
          n.txCur = r.txSet;
          n.txAmt = 13'h0000;
          n.txHalt = 1'b0;
          n.ev[E_TX_BEGUN] = 1'b1;
          n.txSt = TX_FETCH;
        end
      end
      TX_FETCH: begin
        if (r.txHalt || r.txAmt == r.txCur.lim) begin
          n.txSt = TX_END;
        end else if (!r.mem.req && !r.memIsTx) begin
          n.mem = '{1'b1, 1'b0, r.txCur.ptr + {19'h0, r.txAmt}, 8'h00};
          n.memIsTx = 1'b1;
        end else if (r.memIsTx && r.mem.req && memAck) begin
          n.txByte = memRdata;
          n.memIsTx = 1'b0;
          n.txSt = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (r.txHalt) begin
          n.txSt = TX_END;
        end else if (!r.cfg[C_FLOW] || !r.cts2) begin
          n.txSr = {1'b1, ^r.txByte & r.cfg[C_PARITY], r.txByte, 1'b0};
          if (!r.cfg[C_PARITY]) begin
            n.txSr = {2'b11, r.txByte, 1'b0};
          end
          n.txBit = 4'h0;
          n.txCnt = 16'h0000;
          n.txSt = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        n.txLine = r.txSr[0];
        n.txCnt = r.txCnt + 16'h0001;
        if (r.txCnt == r.baud - 16'h0001) begin
          n.txCnt = 16'h0000;
          n.txSr = {1'b1, r.txSr[10:1]};
          n.txBit = r.txBit + 4'h1;
          if (r.txBit == nbits) begin
            n.txLine = 1'b1;
            n.ev[E_BYTE_TX] = 1'b1;
            n.txAmt = r.txAmt + 13'h0001;
            n.txSt = TX_FETCH;
          end
        end
      end
      TX_END: begin
        // Halt during a fetch: let the read finish first
        if (r.memIsTx && r.mem.req && memAck) begin
          n.memIsTx = 1'b0;
        end
        if (!r.memIsTx) begin
          n.ev[E_TX_DONE] = 1'b1;
          if (r.txHalt) begin
            n.ev[E_TX_HALTED] = 1'b1;
          end
          n.txSt = TX_IDLE;
        end
      end
    endcase
    if (r.txSt == TX_WAIT || r.txSt == TX_FETCH) begin
      n.txLine = 1'b1;
    end
    // Receiver framing, sampling at mid bit
    charEnd = 1'b0;
    parErr = 1'b0;
    stopOk = 1'b0;
    if (!r.rxBusy) begin
      // Line must idle high first, so a low stop bit is no new start
      if (r.rx2) begin
        n.rxArmed = 1'b1;
      end else if (r.rxArmed) begin
        n.rxArmed = 1'b0;
        n.rxBusy = 1'b1;
        n.rxCnt = {1'b0, r.baud[15:1]};
        n.rxBit = 4'h0;
      end
    end else if (r.rxCnt == 16'h0000) begin
      n.rxCnt = r.baud - 16'h0001;
      n.rxBit = r.rxBit + 4'h1;
      n.rxSr = {r.rx2, r.rxSr[9:1]};
      if (r.rxBit == 4'h0 && r.rx2) begin
        n.rxBusy = 1'b0;
      end
      if (r.rxBit == (r.cfg[C_PARITY] ? 4'hA : 4'h9)) begin
        n.rxBusy = 1'b0;
        charEnd = 1'b1;
        stopOk = r.rx2;
      end
    end else begin
      n.rxCnt = r.rxCnt - 16'h0001;
    end
    if (charEnd) begin
      if (r.cfg[C_PARITY]) begin
        n.rxSr = {r.rxSr[9:1], 1'b0};
        parErr = ^r.rxSr[9:1];
      end else begin
        n.rxSr = {r.rxSr[9:2], 2'b00};
      end
    end
    if (r.grace != 4'h0) begin
      n.graceCnt = r.graceCnt + 19'h00001;
      if (r.graceCnt == {r.baud, 3'h0} + {3'h0, r.baud} + {2'h0, r.baud,
          1'b0} - 19'h1) begin
        n.graceCnt = 19'h0;
        n.grace = r.grace - 4'h1;
      end
    end
    pushOk = (r.rxSt == RX_ON) || (r.grace != 4'h0);
    if (charEnd) begin
      n.ev[E_BYTE_RX] = 1'b1;
      if (!stopOk || parErr) begin
        n.ev[E_ERROR] = 1'b1;
      end
    end
    if (charEnd && stopOk && pushOk && r.cnt != FIFO_DEPTH[3:0]) begin
      n.fifo[r.wp] = r.cfg[C_PARITY] ? r.rxSr[8:1] : r.rxSr[9:2];
      n.wp = r.wp + 3'h1;
      n.cnt = r.cnt + 4'h1;
    end
    if (r.rxSt != RX_OFF && r.cnt != 4'h0 && r.rxAmt != r.rxCur.lim
        && !r.mem.req && !r.memIsTx && r.txSt != TX_FETCH) begin
      n.mem = '{1'b1, 1'b1, r.rxCur.ptr + {19'h0, r.rxAmt}, r.fifo[r.rp]};
    end
    if (r.mem.req && r.mem.wr && memAck) begin
      n.rp = r.rp + 3'h1;
      n.cnt = n.cnt - 4'h1;
      n.rxAmt = r.rxAmt + 13'h0001;
    end
    unique case (r.rxSt)
      RX_OFF: begin
        if (task_s[T_BEGIN_RX] || task_s[T_DRAIN]) begin
          n.rxCur = r.rxSet;
          n.rxAmt = 13'h0000;
          n.rxDonePend = 1'b0;
          if (task_s[T_BEGIN_RX]) begin
            n.ev[E_RX_BEGUN] = 1'b1;
          end
          n.rxSt = task_s[T_BEGIN_RX] ? RX_ON : RX_DRAINING;
        end
      end
      RX_ON: begin
        // Count stays readable after done until the next begin
        if (r.rxAmt == r.rxCur.lim && !r.mem.req && !r.rxDonePend) begin
          n.ev[E_RX_DONE] = 1'b1;
          n.rxDonePend = 1'b1;
        end
        if (task_s[T_BEGIN_RX]) begin
          n.rxCur = r.rxSet;
          n.rxAmt = 13'h0000;
          n.rxDonePend = 1'b0;
          n.ev[E_RX_BEGUN] = 1'b1;
        end
        if (task_s[T_HALT_RX]) begin
          n.grace = RTS_GRACE;
          n.graceCnt = 19'h0;
          n.rxSt = RX_STOPPING;
        end
      end
      RX_STOPPING: begin
        if (r.grace == 4'h0 && !r.rxBusy && !(r.mem.req && r.mem.wr)) begin
          if (!r.rxDonePend) begin
            n.ev[E_RX_DONE] = 1'b1;
            n.rxDonePend = 1'b1;
          end else begin
            n.ev[E_RX_TO] = 1'b1;
            n.rxDonePend = 1'b0;
            n.rxSt = RX_OFF;
          end
        end
      end
      RX_DRAINING: begin
        if ((r.cnt == 4'h0 || r.rxAmt == r.rxCur.lim) && !r.mem.req) begin
          n.ev[E_RX_DONE] = 1'b1;
          n.rxSt = RX_OFF;
        end
      end
    endcase
    n.rtsN = 1'b0;
    if (r.cfg[C_FLOW] && (r.rxSt != RX_ON || r.cnt >= FIFO_DEPTH[3:0]
        - RTS_ROOM[3:0])) begin
      n.rtsN = 1'b1;
    end
    if (!nrst) begin
      n = '0;
      n.baud = BAUD_RESET;
      n.rxSet.lim = LIM_RESET;
      n.txLine = 1'b1;
      n.rtsN = 1'b1;
      n.cts1 = 1'b1;
      n.cts2 = 1'b1;
      n.rx1 = 1'b1;
      n.rx2 = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    r <= n;
  end
  assign awready = !r.awHave;
  assign wready = !r.wHave;
  assign bvalid = r.bValid;
  assign bresp = r.bResp;
  assign arready = r.arDone;
  assign rvalid = r.rValid;
  assign rdata = r.rData;
  assign rresp = r.rResp;
  assign mem = r.mem;
  assign txLine = r.txLine;
  assign rtsN = r.rtsN;
endmodule : dsp_serial_port
`default_nettype wire
